// ---- src/irq_map_pkg.sv ----
// Shared constants for the interrupt source map and GPIO pair select
package irq_map_pkg;

  // Register bus geometry
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;

  // Register byte offsets
  localparam logic [7:0] OFF_PAIR_SEL = 8'h00;
  localparam logic [7:0] OFF_TRIG_CFG = 8'h04;
  localparam logic [7:0] OFF_STATUS   = 8'h08;
  localparam logic [7:0] OFF_CLEAR    = 8'h0c;
  localparam logic [7:0] OFF_ENABLE   = 8'h10;
  localparam logic [7:0] OFF_REQ_LO   = 8'h14;
  localparam logic [7:0] OFF_REQ_HI   = 8'h18;

  // Values after reset
  localparam logic [31:0] PAIR_SEL_RST = 32'h0000_0000;
  localparam logic [1:0]  TRIG_RST     = 2'h0;
  localparam logic [2:0]  ENABLE_RST   = 3'h0;

  // Bus answers
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_DECERR = 2'h3;

  // Request vector layout
  localparam int REQ_W      = 63;
  localparam int PAIR_BASE  = 34;
  localparam int PAIR_MAX   = 25;
  localparam int EXT_PINS   = 2;
  localparam int LN_RTC     = 2;
  localparam int LN_CRC     = 3;
  localparam int LN_AES     = 4;
  localparam int LN_I2C0    = 5;
  localparam int LN_DMA     = 8;
  localparam int LN_GPIO    = 9;
  localparam int LN_SSP0    = 10;
  localparam int LN_QSPI    = 13;
  localparam int LN_TMR0    = 14;
  localparam int LN_UART0   = 18;
  localparam int LN_WDT     = 22;
  localparam int LN_ADC     = 24;
  localparam int LN_DAC     = 25;
  localparam int LN_ACWAKE  = 26;
  localparam int LN_ANALOG_COMPARATOR   = 27;
  localparam int LN_SDIO    = 28;
  localparam int LN_USB     = 29;
  localparam int LN_PLL     = 31;
  localparam int LN_RCOSC   = 33;
  localparam int LN_ULP     = 60;
  localparam int LN_BROWN   = 61;
  localparam int LN_WLWAKE  = 62;

  // Sticky event bits
  localparam int NUM_EVT  = 3;
  localparam int EVT_EXT0 = 0;
  localparam int EVT_EXT1 = 1;
  localparam int EVT_WDT  = 2;

  // Trigger encoding per external pin
  typedef enum logic {TRIG_LEVEL, TRIG_EDGE} trig_mode_t;

endpackage : irq_map_pkg

// ---- src/pin_sync.sv ----
// Three-stage synchroniser with agreement filter for pin inputs
module pin_sync #(
  parameter int W = 1
) (
  // Clock and reset
  input  wire logic         clk_sys,
  input  wire logic         arst_n,
  // Pins and filtered levels
  input  wire logic [W-1:0] pin_in,
  output logic      [W-1:0] level_out
);

  logic [W-1:0] s1_reg;
  logic [W-1:0] s2_reg;
  logic [W-1:0] s3_reg;
  logic [W-1:0] level_reg;
  logic [W-1:0] level_next;

  // A bit moves only once the second and third stages agree
  assign level_next = (~(s2_reg ^ s3_reg) & s3_reg) | ((s2_reg ^ s3_reg) & level_reg);
  assign level_out  = level_reg;

  // First stage feeds only the second
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      s1_reg    <= '0;
      s2_reg    <= '0;
      s3_reg    <= '0;
      level_reg <= '0;
    end else begin
      s1_reg    <= pin_in;
      s2_reg    <= s1_reg;
      s3_reg    <= s2_reg;
      level_reg <= level_next;
    end
  end

endmodule // pin_sync

// ---- src/pair_select_mux.sv ----
// GPIO pair-select multiplexer for the pin-interrupt lines
module pair_select_mux #(
  parameter int LINES = 25
) (
  // Selects and GPIO levels
  input  wire logic [LINES-1:0]   sel,
  input  wire logic [2*LINES-1:0] gpio,
  output logic      [LINES-1:0]   line_out
);

  initial begin
    if (LINES < 1) $error("pair_select_mux needs at least one line");
  end

  // Set picks the even GPIO of the pair, clear picks the odd one
  for (genvar k = 0; k < LINES; k++) begin : g_pair
    assign line_out[k] = sel[k] ? gpio[2*k] : gpio[2*k+1];
  end

endmodule // pair_select_mux

// ---- src/irq_source_map_gpio_select.sv ----
// Interrupt source map onto processor request lines, with GPIO pair select
//
// Decided for this implementation: register access over AXI4-Lite and the address map.
module irq_source_map_gpio_select
#(
  parameter int PAIR_LINES = 25
) (
  // Clock and reset
  input  wire logic                       clk_sys,
  input  wire logic                       arst_n,
  // Register bus, write channels
  input  wire logic [irq_map_pkg::ADDR_W-1:0] s_axi_awaddr,
  input  wire logic                       s_axi_awvalid,
  output logic                            s_axi_awready,
  input  wire logic [irq_map_pkg::DATA_W-1:0] s_axi_wdata,
  input  wire logic [3:0]                 s_axi_wstrb,
  input  wire logic                       s_axi_wvalid,
  output logic                            s_axi_wready,
  output logic [1:0]                      s_axi_bresp,
  output logic                            s_axi_bvalid,
  input  wire logic                       s_axi_bready,
  // Register bus, read channels
  input  wire logic [irq_map_pkg::ADDR_W-1:0] s_axi_araddr,
  input  wire logic                       s_axi_arvalid,
  output logic                            s_axi_arready,
  output logic [irq_map_pkg::DATA_W-1:0]  s_axi_rdata,
  output logic [1:0]                      s_axi_rresp,
  output logic                            s_axi_rvalid,
  input  wire logic                       s_axi_rready,
  // Pins
  input  wire logic [irq_map_pkg::EXT_PINS-1:0] ext_pin,
  input  wire logic [2*PAIR_LINES-1:0]    gpio_pin,
  // On-chip sources, same clock
  input  wire logic                       rtc_req,
  input  wire logic                       checksum_req,
  input  wire logic                       cipher_req,
  input  wire logic [1:0]                 i2c_req,
  input  wire logic                       dma_controller_req,
  input  wire logic                       gpio_unit_req,
  input  wire logic [2:0]                 sync_serial_port_req,
  input  wire logic                       qspi_req,
  input  wire logic [3:0]                 general_timer_req,
  input  wire logic [2:0]                 uart_req,
  input  wire logic                       watchdog_unit_req,
  input  wire logic                       watchdog_unit_timeout,
  input  wire logic                       adc_req,
  input  wire logic                       dac_req,
  input  wire logic                       analog_comparator_wake_req,
  input  wire logic                       analog_comparator_req,
  input  wire logic                       sdio_req,
  input  wire logic                       usb_req,
  input  wire logic                       power_manager_pll_req,
  input  wire logic                       fast_rc_oscillator_req,
  input  wire logic                       ultra_low_power_comparator_req,
  input  wire logic                       brownout_detector_req,
  input  wire logic                       wireless_wake_req,
  // Processor side
  output logic [irq_map_pkg::REQ_W-1:0]   cpu_request_vector,
  output logic                            nonmaskable_line,
  output logic                            irq_out
);
  import irq_map_pkg::*;

  initial begin
    if (PAIR_LINES < 1 || PAIR_LINES > PAIR_MAX) $error("PAIR_LINES must be 1..25");
  end

  // Merge written bytes into an old word
  function automatic logic [31:0] merge_bytes(input logic [31:0] old_w,
                                              input logic [31:0] new_w,
                                              input logic [3:0]  strb);
    logic [31:0] res;
    res = old_w;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) res[8*b +: 8] = new_w[8*b +: 8];
    end
    return res;
  endfunction

  // Register state
  logic [PAIR_LINES-1:0] pair_sel_reg;
  logic [1:0]            trig_cfg_reg;
  logic [NUM_EVT-1:0]    status_reg;
  logic [NUM_EVT-1:0]    status_next;
  logic [NUM_EVT-1:0]    enable_reg;
  logic [REQ_W-1:0]      req_vec_reg;
  logic [REQ_W-1:0]      req_vec_next;
  logic                  nmi_reg;
  logic                  irq_reg;
  logic [1:0]            ext_prev_reg;
  logic                  wdt_prev_reg;

  // Bus state
  logic                  aw_held_reg;
  logic                  w_held_reg;
  logic [ADDR_W-1:0]     awaddr_reg;
  logic [31:0]           wdata_reg;
  logic [3:0]            wstrb_reg;
  logic                  bvalid_reg;
  logic [1:0]            bresp_reg;
  logic                  awready_reg;
  logic                  wready_reg;
  logic                  arready_reg;
  logic                  rvalid_reg;
  logic [31:0]           rdata_reg;
  logic [1:0]            rresp_reg;

  // Synchronised pins and pair mux
  logic [EXT_PINS-1:0]     ext_lvl;
  logic [2*PAIR_LINES-1:0] gpio_lvl;
  logic [PAIR_LINES-1:0]   pair_line;

  pin_sync #(.W(EXT_PINS)) u_ext_sync (
    .clk_sys   (clk_sys),
    .arst_n    (arst_n),
    .pin_in    (ext_pin),
    .level_out (ext_lvl)
  );

  pin_sync #(.W(2*PAIR_LINES)) u_gpio_sync (
    .clk_sys   (clk_sys),
    .arst_n    (arst_n),
    .pin_in    (gpio_pin),
    .level_out (gpio_lvl)
  );

  pair_select_mux #(.LINES(PAIR_LINES)) u_pair_mux (
    .sel      (pair_sel_reg),
    .gpio     (gpio_lvl),
    .line_out (pair_line)
  );

  // Write channel decode
  logic       aw_take;
  logic       w_take;
  logic       wr_fire;
  logic [7:0] wr_off;
  logic       wr_hit;
  assign aw_take = s_axi_awvalid & awready_reg;
  assign w_take  = s_axi_wvalid & wready_reg;
  assign wr_fire = aw_held_reg & w_held_reg & ~bvalid_reg;
  assign wr_off  = {awaddr_reg[ADDR_W-1:2], 2'b00};
  assign wr_hit  = (wr_off == OFF_PAIR_SEL) | (wr_off == OFF_TRIG_CFG) |
                   (wr_off == OFF_CLEAR) | (wr_off == OFF_ENABLE);

  logic [31:0] pair_merged;
  logic [31:0] trig_merged;
  logic [31:0] enable_merged;
  logic [31:0] clear_word;
  assign pair_merged   = merge_bytes(32'(pair_sel_reg), wdata_reg, wstrb_reg);
  assign trig_merged   = merge_bytes(32'(trig_cfg_reg), wdata_reg, wstrb_reg);
  assign enable_merged = merge_bytes(32'(enable_reg), wdata_reg, wstrb_reg);
  assign clear_word    = merge_bytes(32'h0000_0000, wdata_reg, wstrb_reg);

  logic wr_pair;
  logic wr_trig;
  logic wr_enable;
  logic wr_clear;
  assign wr_pair   = wr_fire & (wr_off == OFF_PAIR_SEL);
  assign wr_trig   = wr_fire & (wr_off == OFF_TRIG_CFG);
  assign wr_enable = wr_fire & (wr_off == OFF_ENABLE);
  assign wr_clear  = wr_fire & (wr_off == OFF_CLEAR);

  // Sticky events; a new event beats a clear in the same cycle
  logic [NUM_EVT-1:0] evt_set;
  logic [NUM_EVT-1:0] evt_clr;
  assign evt_set[EVT_EXT0] = ext_lvl[0] & ~ext_prev_reg[0];
  assign evt_set[EVT_EXT1] = ext_lvl[1] & ~ext_prev_reg[1];
  assign evt_set[EVT_WDT]  = watchdog_unit_timeout & ~wdt_prev_reg;
  assign evt_clr     = wr_clear ? clear_word[NUM_EVT-1:0] : '0;
  assign status_next = (status_reg & ~evt_clr) | evt_set;

  // External pins: level follows the pin, edge holds until cleared
  logic [EXT_PINS-1:0] ext_line;
  for (genvar p = 0; p < EXT_PINS; p++) begin : g_ext
    assign ext_line[p] = (trig_mode_t'(trig_cfg_reg[p]) == TRIG_EDGE) ?
                         status_reg[p] : ext_lvl[p];
  end

  // Request vector assembly, one line per source
  assign req_vec_next[1:0]              = ext_line;
  assign req_vec_next[LN_RTC]           = rtc_req;
  assign req_vec_next[LN_CRC]           = checksum_req;
  assign req_vec_next[LN_AES]           = cipher_req;
  assign req_vec_next[LN_I2C0 +: 2]     = i2c_req;
  assign req_vec_next[7]                = 1'b0;
  assign req_vec_next[LN_DMA]           = dma_controller_req;
  assign req_vec_next[LN_GPIO]          = gpio_unit_req;
  assign req_vec_next[LN_SSP0 +: 3]     = sync_serial_port_req;
  assign req_vec_next[LN_QSPI]          = qspi_req;
  assign req_vec_next[LN_TMR0 +: 4]     = general_timer_req;
  assign req_vec_next[LN_UART0 +: 3]    = uart_req;
  assign req_vec_next[21]               = 1'b0;
  assign req_vec_next[LN_WDT]           = watchdog_unit_req;
  assign req_vec_next[23]               = 1'b0;
  assign req_vec_next[LN_ADC]           = adc_req;
  assign req_vec_next[LN_DAC]           = dac_req;
  assign req_vec_next[LN_ACWAKE]        = analog_comparator_wake_req;
  assign req_vec_next[LN_ANALOG_COMPARATOR]         = analog_comparator_req;
  assign req_vec_next[LN_SDIO]          = sdio_req;
  assign req_vec_next[LN_USB]           = usb_req;
  assign req_vec_next[30]               = 1'b0;
  assign req_vec_next[LN_PLL]           = power_manager_pll_req;
  assign req_vec_next[32]               = 1'b0;
  assign req_vec_next[LN_RCOSC]         = fast_rc_oscillator_req;
  assign req_vec_next[LN_ULP]           = ultra_low_power_comparator_req;
  assign req_vec_next[LN_BROWN]         = brownout_detector_req;
  assign req_vec_next[LN_WLWAKE]        = wireless_wake_req;
  assign req_vec_next[59]               = 1'b0;

  // Pin lines beyond the configured pair count stay quiet
  for (genvar k = 0; k < PAIR_MAX; k++) begin : g_pin_line
    if (k < PAIR_LINES) begin : g_used
      assign req_vec_next[PAIR_BASE+k] = pair_line[k];
    end else begin : g_unused
      assign req_vec_next[PAIR_BASE+k] = 1'b0;
    end
  end

  // Read decode
  logic       ar_take;
  logic [7:0] rd_off;
  logic       rd_hit;
  logic [31:0] rd_word;
  assign ar_take = s_axi_arvalid & arready_reg;
  assign rd_off  = {s_axi_araddr[ADDR_W-1:2], 2'b00};
  assign rd_hit  = (rd_off == OFF_PAIR_SEL) | (rd_off == OFF_TRIG_CFG) |
                   (rd_off == OFF_STATUS) | (rd_off == OFF_CLEAR) |
                   (rd_off == OFF_ENABLE) | (rd_off == OFF_REQ_LO) | (rd_off == OFF_REQ_HI);
  assign rd_word = (rd_off == OFF_PAIR_SEL) ? 32'(pair_sel_reg) :
                   (rd_off == OFF_TRIG_CFG) ? 32'(trig_cfg_reg) :
                   (rd_off == OFF_STATUS)   ? 32'(status_reg)   :
                   (rd_off == OFF_ENABLE)   ? 32'(enable_reg)   :
                   (rd_off == OFF_REQ_LO)   ? req_vec_reg[31:0] :
                   (rd_off == OFF_REQ_HI)   ? 32'(req_vec_reg[REQ_W-1:32]) : 32'h0000_0000;

  // Control registers
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      pair_sel_reg <= PAIR_SEL_RST[PAIR_LINES-1:0];
      trig_cfg_reg <= TRIG_RST;
      enable_reg   <= ENABLE_RST;
      status_reg   <= '0;
      ext_prev_reg <= '0;
      wdt_prev_reg <= 1'b0;
    end else begin
      if (wr_pair) pair_sel_reg <= pair_merged[PAIR_LINES-1:0];
      if (wr_trig) trig_cfg_reg <= trig_merged[1:0];
      if (wr_enable) enable_reg <= enable_merged[NUM_EVT-1:0];
      status_reg   <= status_next;
      ext_prev_reg <= ext_lvl;
      wdt_prev_reg <= watchdog_unit_timeout;
    end
  end

  // Outputs to the processor, all registered
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      req_vec_reg <= '0;
      nmi_reg     <= 1'b0;
      irq_reg     <= 1'b0;
    end else begin
      req_vec_reg <= req_vec_next;
      nmi_reg     <= watchdog_unit_timeout;
      irq_reg     <= |(status_next & enable_reg);
    end
  end

  // Write side: address and data taken in either order, then one response
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      aw_held_reg <= 1'b0;
      w_held_reg  <= 1'b0;
      awaddr_reg  <= '0;
      wdata_reg   <= '0;
      wstrb_reg   <= '0;
      bvalid_reg  <= 1'b0;
      bresp_reg   <= RESP_OKAY;
      awready_reg <= 1'b0;
      wready_reg  <= 1'b0;
    end else begin
      if (aw_take) awaddr_reg <= s_axi_awaddr;
      if (w_take) begin
        wdata_reg <= s_axi_wdata;
        wstrb_reg <= s_axi_wstrb;
      end
      aw_held_reg <= (aw_held_reg | aw_take) & ~wr_fire;
      w_held_reg  <= (w_held_reg | w_take) & ~wr_fire;
      awready_reg <= ~((aw_held_reg | aw_take) & ~wr_fire) & ~awready_reg;
      wready_reg  <= ~((w_held_reg | w_take) & ~wr_fire) & ~wready_reg;
      if (wr_fire) begin
        bvalid_reg <= 1'b1;
        bresp_reg  <= wr_hit ? RESP_OKAY : RESP_DECERR;
      end else if (s_axi_bready) begin
        bvalid_reg <= 1'b0;
      end
    end
  end

  // Read side: one read at a time, ready drops while data waits
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      arready_reg <= 1'b0;
      rvalid_reg  <= 1'b0;
      rdata_reg   <= '0;
      rresp_reg   <= RESP_OKAY;
    end else begin
      if (ar_take) begin
        rvalid_reg <= 1'b1;
        rdata_reg  <= rd_word;
        rresp_reg  <= rd_hit ? RESP_OKAY : RESP_DECERR;
      end else if (s_axi_rready) begin
        rvalid_reg <= 1'b0;
      end
      arready_reg <= ~ar_take & ~(rvalid_reg & ~s_axi_rready) & ~arready_reg;
    end
  end

  // Port drive
  assign s_axi_awready      = awready_reg;
  assign s_axi_wready       = wready_reg;
  assign s_axi_bvalid       = bvalid_reg;
  assign s_axi_bresp        = bresp_reg;
  assign s_axi_arready      = arready_reg;
  assign s_axi_rvalid       = rvalid_reg;
  assign s_axi_rdata        = rdata_reg;
  assign s_axi_rresp        = rresp_reg;
  assign cpu_request_vector = req_vec_reg;
  assign nonmaskable_line   = nmi_reg;
  assign irq_out            = irq_reg;

  // Checks on the mapping, one clock domain
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!arst_n);

  AST_NMI_FROM_TIMEOUT: assert property (
    nonmaskable_line == $past(watchdog_unit_timeout) &&
    cpu_request_vector[LN_WDT] == $past(watchdog_unit_req))
    else $error("nonmaskable line wrong");
  AST_RTC_LINE: assert property (
    cpu_request_vector[LN_RTC] == $past(rtc_req) &&
    cpu_request_vector[LN_AES] == $past(cipher_req)) else $error("rtc or cipher line wrong");
  AST_I2C_DMA_LINES: assert property (
    $rose(i2c_req[1]) |=> cpu_request_vector[6] && cpu_request_vector[LN_DMA] ==
    $past(dma_controller_req)) else $error("i2c or dma line wrong");
  AST_SERIAL_LINES: assert property (
    cpu_request_vector[12:10] == $past(sync_serial_port_req)) else $error("serial lines wrong");
  AST_TIMER_ORDER: assert property (
    cpu_request_vector[17:14] == $past(general_timer_req)) else $error("timer lines wrong");
  AST_UART_WDT: assert property (
    cpu_request_vector[20:18] == $past(uart_req) &&
    cpu_request_vector[LN_WDT] == $past(watchdog_unit_req)) else $error("uart or wdt wrong");
  AST_ANALOG_LINES: assert property (
    $fell(adc_req) |=> !cpu_request_vector[LN_ADC] && cpu_request_vector[LN_ANALOG_COMPARATOR] ==
    $past(analog_comparator_req)) else $error("analog lines wrong");
  AST_SYS_LINES: assert property (
    cpu_request_vector[LN_USB] == $past(usb_req) &&
    cpu_request_vector[LN_RCOSC] == $past(fast_rc_oscillator_req)) else $error("sys lines wrong");
  AST_AON_LINES: assert property (
    brownout_detector_req [*2] |-> cpu_request_vector[LN_BROWN]) else $error("brownout lost");
  AST_SPARE_LOW: assert property (
    !cpu_request_vector[7] && !cpu_request_vector[21] && !cpu_request_vector[23] &&
    !cpu_request_vector[30] && !cpu_request_vector[32] && !cpu_request_vector[59])
    else $error("spare line raised");
  AST_PAIR_SELECT: assert property (
    cpu_request_vector[PAIR_BASE] == $past(pair_sel_reg[0] ? gpio_lvl[0] : gpio_lvl[1]))
    else $error("pair line 0 wrong");
  AST_EXT_LEVEL: assert property (
    trig_cfg_reg[0] == 1'b0 && $stable(trig_cfg_reg) |=> cpu_request_vector[0] ==
    $past(ext_lvl[0])) else $error("level pin line wrong");
  AST_EXT_EDGE_HOLD: assert property (
    trig_cfg_reg[1] && $rose(ext_lvl[1]) && $stable(trig_cfg_reg) |=> status_reg[EVT_EXT1]
    ##1 cpu_request_vector[1]) else $error("edge pin not held");
  // Enable takes effect one cycle late because the output is registered
  AST_IRQ_FOLLOWS: assert property (
    irq_out == |(status_reg & $past(enable_reg))) else $error("interrupt output wrong");

  COV_EDGE_PIN: cover property (trig_cfg_reg[0] ##1 $rose(cpu_request_vector[0]));
  COV_PAIR_EVEN: cover property (pair_sel_reg[0] && $rose(cpu_request_vector[PAIR_BASE]));
  COV_NMI: cover property ($rose(nonmaskable_line) ##[1:4] irq_out);
  COV_CLEAR: cover property (wr_clear && evt_set != '0);

endmodule // irq_source_map_gpio_select

// ---- sim/cpu_irq_inputs.sv ----
// Processor-side model: interrupt inputs sampling the request levels
module cpu_irq_inputs (
  // Clock and reset
  input  wire logic        clk_sys,
  input  wire logic        arst_n,
  // Levels from the map
  input  wire logic [62:0] req,
  input  wire logic        nmi,
  // Levels as the core sees them
  output logic      [63:0] pending
);
  timeunit 1ns;
  timeprecision 1ps;
  // Level sampling only; a source must hold its line until serviced
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) pending <= '0;
    else pending <= {nmi, req};
  end
endmodule // cpu_irq_inputs

// ---- sim/irq_source_map_gpio_select_tb_top.sv ----
// Bench for the interrupt source map and GPIO pair select
module irq_source_map_gpio_select_tb_top import irq_map_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_sys = 0, arst_n = 0, awv = 0, wv = 0, bre = 0, arv = 0, rre = 0, wdt_to = 0;
  logic        awr, wrd, bv, arr, rv, nmi, irq;
  logic [7:0]  awa = 0, ara = 0;
  logic [31:0] wd = 0, d, rdat;
  logic [1:0]  ext = 0, rsp, bresp, rresp;
  logic [49:0] gp = 0;
  logic [29:0] src = 0;
  logic [62:0] vec;
  logic [63:0] pend;
  int          err_total = 0, checks = 0, i;
  byte ln [30] = '{2, 3, 4, 5, 6, 8, 9, 10, 11, 12, 13, 14, 15, 16, 17, 18, 19, 20, 22, 24, 25,
                   26, 27, 28, 29, 31, 33, 60, 61, 62};
  irq_source_map_gpio_select #(.PAIR_LINES(25)) uut (
    .clk_sys(clk_sys), .arst_n(arst_n), .s_axi_awaddr(awa), .s_axi_awvalid(awv),
    .s_axi_awready(awr), .s_axi_wdata(wd), .s_axi_wstrb(4'hf), .s_axi_wvalid(wv),
    .s_axi_wready(wrd), .s_axi_bresp(bresp), .s_axi_bvalid(bv), .s_axi_bready(bre),
    .s_axi_araddr(ara), .s_axi_arvalid(arv), .s_axi_arready(arr), .s_axi_rdata(rdat),
    .s_axi_rresp(rresp), .s_axi_rvalid(rv), .s_axi_rready(rre), .ext_pin(ext), .gpio_pin(gp),
    .rtc_req(src[0]), .checksum_req(src[1]), .cipher_req(src[2]), .i2c_req(src[4:3]),
    .dma_controller_req(src[5]), .gpio_unit_req(src[6]), .sync_serial_port_req(src[9:7]),
    .qspi_req(src[10]), .general_timer_req(src[14:11]), .uart_req(src[17:15]),
    .watchdog_unit_req(src[18]), .watchdog_unit_timeout(wdt_to), .adc_req(src[19]),
    .dac_req(src[20]), .analog_comparator_wake_req(src[21]), .analog_comparator_req(src[22]),
    .sdio_req(src[23]), .usb_req(src[24]), .power_manager_pll_req(src[25]),
    .fast_rc_oscillator_req(src[26]), .ultra_low_power_comparator_req(src[27]),
    .brownout_detector_req(src[28]), .wireless_wake_req(src[29]), .cpu_request_vector(vec),
    .nonmaskable_line(nmi), .irq_out(irq));
  cpu_irq_inputs cpu (.clk_sys(clk_sys), .arst_n(arst_n), .req(vec), .nmi(nmi), .pending(pend));
  // Free-running system clock
  initial forever #5 clk_sys = ~clk_sys;
  task automatic summarize();
    if (err_total == 0 && checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  task automatic lim(input int n);
    if (n >= 50) begin
      err_total++;
      summarize();
    end
  endtask
  task automatic chk(input logic [62:0] got, input logic [62:0] exp);
    checks++;
    if (got !== exp) begin
      err_total++;
      $display("Error t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  // Address and data go out together; each valid drops at its own handshake
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    int n = 0;
    awa <= a;
    wd <= v;
    {awv, wv, bre} <= 3'h7;
    do begin
      @(posedge clk_sys);
      if (awr) awv <= 1'b0;
      if (wrd) wv <= 1'b0;
    end while (!bv && ++n < 50);
    rsp = bresp;
    lim(n);
  endtask
  task automatic rd(input logic [7:0] a);
    int n = 0;
    ara <= a;
    {arv, rre} <= 2'h3;
    do begin
      @(posedge clk_sys);
      if (arr) arv <= 1'b0;
    end while (!rv && ++n < 50);
    d = rdat;
    rsp = rresp;
    lim(n);
  endtask
  // Main sequence; GPIO and pin paths get 8 cycles for the synchronisers
  initial begin
    repeat (8) @(posedge clk_sys);
    arst_n <= 1'b1;
    @(posedge clk_sys);
    rd(OFF_PAIR_SEL);
    chk(d, PAIR_SEL_RST);
    rd(8'hf0);
    chk(rsp, RESP_DECERR);
    for (i = 0; i < 30; i++) begin
      src <= 30'h1 << i;
      repeat (3) @(posedge clk_sys);
      chk(pend[62:0], 63'h1 << ln[i]);
    end
    src <= '0;
    wr(OFF_ENABLE, 32'h4);
    wdt_to <= 1'b1;
    repeat (4) @(posedge clk_sys);
    chk(pend[63], 1'b1);
    chk(irq, 1'b1);
    rd(OFF_STATUS);
    chk(d, 32'h4);
    wdt_to <= 1'b0;
    wr(OFF_CLEAR, 32'h4);
    repeat (3) @(posedge clk_sys);
    chk(irq, 1'b0);
    ext <= 2'h3;
    repeat (8) @(posedge clk_sys);
    chk({irq, pend[1:0]}, 3'h3);
    ext <= 2'h0;
    repeat (8) @(posedge clk_sys);
    chk(pend[1:0], 2'h0);
    wr(OFF_CLEAR, 32'h3);
    wr(OFF_TRIG_CFG, 32'h3);
    ext <= 2'h1;
    repeat (8) @(posedge clk_sys);
    ext <= 2'h0;
    repeat (8) @(posedge clk_sys);
    chk(pend[1:0], 2'h1);
    ext <= 2'h2;
    repeat (8) @(posedge clk_sys);
    ext <= 2'h0;
    repeat (8) @(posedge clk_sys);
    chk(pend[1:0], 2'h3);
    wr(OFF_CLEAR, 32'h3);
    chk(rsp, RESP_OKAY);
    repeat (3) @(posedge clk_sys);
    chk(pend[1:0], 2'h0);
    wr(OFF_STATUS, 32'h7);
    chk(rsp, RESP_DECERR);
    gp <= 50'h1555555555555;
    wr(OFF_PAIR_SEL, 32'h01555555);
    rd(OFF_PAIR_SEL);
    chk(d, 32'h01555555);
    repeat (8) @(posedge clk_sys);
    chk(pend[58:34], 25'h1555555);
    gp <= 50'h2aaaaaaaaaaaa;
    repeat (8) @(posedge clk_sys);
    chk(pend[58:34], 25'h0aaaaaa);
    rd(OFF_REQ_HI);
    chk(d, 32'h02aaaaa8);
    summarize();
  end
endmodule // irq_source_map_gpio_select_tb_top
